//--- pao_port_a_override.sv
// Port A alternate function override logic with registered pad controls
//
// Contract
// R1: UART receiver enabled forces pin 0 to input.
// R2: LIN enabled forces pin 0 to input regardless of direction bit.
// R3: Pin 0 forced input turns on pull-up when its port bit is one.
// R4: Pin 0 pull-up and direction overrides follow receive active; direction 0, no value override.
// R5: Pin 1 under LIN transmit: output, drives LIN transmit bit, pull-up value 0.
// R6: Pin 2 under SPI master: pull-up and direction overridden, direction input.
// R7: Pin 2 value priority: SPI slave data, serial shift-out, timer 0 compare A.
// R8: Pin 3 input override by analog disable, external irq 1, or pin-change mask.
// R9: Pins 0,1,2,6,7 input override by analog disable or enabled pin-change mask.
// R10: Pin 7 gets no pull-up, direction, value or toggle override.
// R11: Pins 4-6 pull-up override under SPI master; value is port bit AND pull-up disable.
// R12: Pins 4,5 direction and value overrides under SPI master or two-wire alternate mode; code needs the direction bit for the two-wire value.
// R13: Pin 5 drives SPI clock as master, else inverse of two-wire open-drain term.
// R14: Pin 5 direction value is (clock hold OR port bit) AND direction bit 6.
// R15: Pin 4 drives SPI master data, else inverse of two-wire open-drain term.
// R16: Pin 4 direction value 0 as SPI master, else (shift-out OR port) AND direction.
// R17: Pin 5 toggle override when serial toggle requested on alternate pins.
// R18: Pins 4,5 input forced on by start-detect interrupt on alternate pins.
// R19: Asserted override enable selects override value, else port register value; input enable falls back to DEFAULT_DIG_IN_EN.
// R20: Pull-up active only when requested, pin is input, global disable clear.
`timescale 1ns/1ps

module pao_port_a_override (
	// Clock and reset
	input  wire logic                        I_SYS_CLK,
	input  wire logic                        I_RST_N,
	// Port registers
	input  wire logic [pao_pkg::NUM_PINS-1:0] I_PORT_OUTPUT_BIT,
	input  wire logic [pao_pkg::NUM_PINS-1:0] I_DIRECTION_BIT,
	input  wire logic                        I_GLOBAL_PULLUP_DISABLE,
	// SPI
	input  wire logic                        I_SPI_ENABLE_BIT,
	input  wire logic                        I_SPI_MASTER_SELECT,
	input  wire logic                        I_SPI_CLOCK_OUT,
	input  wire logic                        I_SPI_MASTER_DATA_OUT,
	input  wire logic                        I_SPI_SLAVE_DATA_OUT,
	// UART and LIN
	input  wire logic                        I_UART_RX_ENABLE,
	input  wire logic                        I_LIN_RX_ENABLE,
	input  wire logic                        I_LIN_TX_ENABLE,
	input  wire logic                        I_LIN_TX_BIT,
	// Universal serial interface
	input  wire logic                        I_TWO_WIRE_MODE_ACTIVE,
	input  wire logic                        I_THREE_WIRE_MODE_ACTIVE,
	input  wire logic                        I_SERIAL_ALT_PIN_SELECT,
	input  wire logic                        I_SHIFTER_MSB_OUT,
	input  wire logic                        I_CLOCK_STRETCH_HOLD,
	input  wire logic                        I_TOGGLE_REQUEST,
	input  wire logic                        I_START_DETECT_IRQ_ENABLE,
	// Timer 0
	input  wire logic                        I_TIMER0_COMPARE_A_OUT,
	input  wire logic                        I_TIMER0_COMPARE_A_ENABLE,
	// Interrupts and analog
	input  wire logic                        I_EXT_IRQ1_ENABLE,
	input  wire logic                        I_PIN_CHANGE_GROUP_ENABLE,
	input  wire logic [pao_pkg::NUM_PINS-1:0] I_PIN_CHANGE_MASK_BIT,
	input  wire logic [pao_pkg::NUM_PINS-1:0] I_ANALOG_PIN_DIGITAL_DISABLE,
	// Pads
	input  wire logic [pao_pkg::NUM_PINS-1:0] I_PAD_IN,
	output logic      [pao_pkg::NUM_PINS-1:0] O_PAD_OUT,
	output logic      [pao_pkg::NUM_PINS-1:0] O_PAD_OE,
	output logic      [pao_pkg::NUM_PINS-1:0] O_PULLUP_ON,
	// Back to port and peripherals
	output logic      [pao_pkg::NUM_PINS-1:0] O_PORT_TOGGLE,
	output logic      [pao_pkg::NUM_PINS-1:0] O_DIGITAL_INPUT_ENABLE,
	output logic      [pao_pkg::NUM_PINS-1:0] O_PIN_IN
);
	import pao_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Shared conditions
	logic spi_master;
	logic two_wire_alt;
	logic usi_do_alt;
	logic rx_active;
	logic pc_en;
	logic start_alt;

	assign spi_master   = I_SPI_ENABLE_BIT & I_SPI_MASTER_SELECT;
	assign two_wire_alt = I_TWO_WIRE_MODE_ACTIVE & I_SERIAL_ALT_PIN_SELECT;
	assign usi_do_alt   = I_TWO_WIRE_MODE_ACTIVE & I_THREE_WIRE_MODE_ACTIVE & I_SERIAL_ALT_PIN_SELECT;
	assign rx_active    = I_UART_RX_ENABLE | I_LIN_RX_ENABLE; // see R1 see R2
	assign pc_en        = I_PIN_CHANGE_GROUP_ENABLE;
	assign start_alt    = I_START_DETECT_IRQ_ENABLE & I_SERIAL_ALT_PIN_SELECT;

	////////////////////////////////////////////////////////////////////////
	// Override enables and values per pin
	logic [NUM_PINS-1:0] pullup_override_enable;
	logic [NUM_PINS-1:0] pullup_override_value;
	logic [NUM_PINS-1:0] direction_override_enable;
	logic [NUM_PINS-1:0] direction_override_value;
	logic [NUM_PINS-1:0] output_value_override_enable;
	logic [NUM_PINS-1:0] output_value_override_value;
	logic [NUM_PINS-1:0] toggle_override_enable;
	logic [NUM_PINS-1:0] input_enable_override_enable;
	logic [NUM_PINS-1:0] input_enable_override_value;

	// Override table
	always_comb begin
		pullup_override_enable = '0;
		pullup_override_value = '0;
		direction_override_enable = '0;
		direction_override_value = '0;
		output_value_override_enable = '0;
		output_value_override_value = '0;
		toggle_override_enable = '0;
		// Pin 7 keeps only the input disable path
		input_enable_override_enable = I_ANALOG_PIN_DIGITAL_DISABLE
			| (I_PIN_CHANGE_MASK_BIT & {NUM_PINS{pc_en}}); // see R9 see R10
		input_enable_override_value = I_PIN_CHANGE_MASK_BIT & {NUM_PINS{pc_en}}; // see R9

		// Pin 0: receive input with pull-up from port bit
		pullup_override_enable[PIN_RXD] = rx_active; // see R4
		pullup_override_value[PIN_RXD] = I_PORT_OUTPUT_BIT[PIN_RXD] & ~I_GLOBAL_PULLUP_DISABLE; // see R3
		direction_override_enable[PIN_RXD] = rx_active; // see R1 see R2 see R4
		direction_override_value[PIN_RXD] = 1'b0; // see R4

		// Pin 1: LIN transmit output
		pullup_override_enable[PIN_TXD] = I_LIN_TX_ENABLE; // see R5
		pullup_override_value[PIN_TXD] = 1'b0; // see R5
		direction_override_enable[PIN_TXD] = I_LIN_TX_ENABLE; // see R5
		direction_override_value[PIN_TXD] = I_LIN_TX_ENABLE;
		output_value_override_enable[PIN_TXD] = I_LIN_TX_ENABLE;
		output_value_override_value[PIN_TXD] = I_LIN_TX_ENABLE & I_LIN_TX_BIT; // see R5

		// Pin 2: SPI data input as master, value by priority otherwise
		pullup_override_enable[PIN_MISO] = spi_master; // see R6
		pullup_override_value[PIN_MISO] = I_PORT_OUTPUT_BIT[PIN_MISO] & I_GLOBAL_PULLUP_DISABLE;
		direction_override_enable[PIN_MISO] = spi_master; // see R6
		direction_override_value[PIN_MISO] = 1'b0;
		output_value_override_enable[PIN_MISO] = spi_master | usi_do_alt | I_TIMER0_COMPARE_A_ENABLE;
		if (spi_master) begin
			output_value_override_value[PIN_MISO] = I_SPI_SLAVE_DATA_OUT; // see R7
		end else if (usi_do_alt) begin
			output_value_override_value[PIN_MISO] = I_SHIFTER_MSB_OUT; // see R7
		end else begin
			output_value_override_value[PIN_MISO] = I_TIMER0_COMPARE_A_OUT; // see R7
		end

		// Pin 3: external interrupt keeps the input alive
		pullup_override_value[PIN_INT1] = I_PORT_OUTPUT_BIT[PIN_INT1] & I_GLOBAL_PULLUP_DISABLE;
		input_enable_override_enable[PIN_INT1] = I_ANALOG_PIN_DIGITAL_DISABLE[PIN_INT1] | I_EXT_IRQ1_ENABLE
			| (pc_en & I_PIN_CHANGE_MASK_BIT[PIN_INT1]); // see R8
		input_enable_override_value[PIN_INT1] = I_EXT_IRQ1_ENABLE
			| (pc_en & I_PIN_CHANGE_MASK_BIT[PIN_INT1]); // see R8

		// Pin 4: SPI master data or two-wire data
		pullup_override_enable[PIN_MOSI] = spi_master; // see R11
		pullup_override_value[PIN_MOSI] = I_PORT_OUTPUT_BIT[PIN_MOSI]
			& I_GLOBAL_PULLUP_DISABLE; // see R11
		direction_override_enable[PIN_MOSI] = spi_master | two_wire_alt; // see R12
		direction_override_value[PIN_MOSI] = spi_master ? 1'b0
			: ((I_SHIFTER_MSB_OUT | I_PORT_OUTPUT_BIT[PIN_MOSI]) & I_DIRECTION_BIT[PIN_MOSI]); // see R16
		output_value_override_enable[PIN_MOSI] = spi_master
			| (two_wire_alt & I_DIRECTION_BIT[PIN_MOSI]); // see R12
		output_value_override_value[PIN_MOSI] = spi_master ? I_SPI_MASTER_DATA_OUT
			: ~(two_wire_alt & I_DIRECTION_BIT[PIN_MOSI]); // see R15
		input_enable_override_enable[PIN_MOSI] = input_enable_override_enable[PIN_MOSI]
			| start_alt; // see R18
		input_enable_override_value[PIN_MOSI] = input_enable_override_value[PIN_MOSI]
			| start_alt; // see R18

		// Pin 5: SPI clock or two-wire clock with stretching
		pullup_override_enable[PIN_SCK] = spi_master; // see R11
		pullup_override_value[PIN_SCK] = I_PORT_OUTPUT_BIT[PIN_SCK]
			& I_GLOBAL_PULLUP_DISABLE; // see R11
		direction_override_enable[PIN_SCK] = spi_master | two_wire_alt; // see R12
		direction_override_value[PIN_SCK] = (I_CLOCK_STRETCH_HOLD | I_PORT_OUTPUT_BIT[PIN_SCK])
			& I_DIRECTION_BIT[PIN_SS]; // see R14
		output_value_override_enable[PIN_SCK] = spi_master
			| (two_wire_alt & I_DIRECTION_BIT[PIN_SCK]); // see R12
		output_value_override_value[PIN_SCK] = spi_master ? I_SPI_CLOCK_OUT
			: ~(two_wire_alt & I_DIRECTION_BIT[PIN_SCK]); // see R13
		toggle_override_enable[PIN_SCK] = I_TOGGLE_REQUEST & I_SERIAL_ALT_PIN_SELECT; // see R17
		input_enable_override_enable[PIN_SCK] = input_enable_override_enable[PIN_SCK]
			| start_alt; // see R18
		input_enable_override_value[PIN_SCK] = input_enable_override_value[PIN_SCK]
			| start_alt; // see R18

		// Pin 6: slave select
		pullup_override_enable[PIN_SS] = spi_master; // see R11
		pullup_override_value[PIN_SS] = I_PORT_OUTPUT_BIT[PIN_SS] & I_GLOBAL_PULLUP_DISABLE; // see R11
		direction_override_enable[PIN_SS] = spi_master;
		direction_override_value[PIN_SS] = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// Per-pin resolution of overrides against the port registers
	logic [NUM_PINS-1:0] eff_dir;
	logic [NUM_PINS-1:0] eff_out;
	logic [NUM_PINS-1:0] eff_pull;
	logic [NUM_PINS-1:0] eff_die;

	genvar gi;
	generate
		for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
			assign eff_dir[gi]  = direction_override_enable[gi] ? direction_override_value[gi]
				: I_DIRECTION_BIT[gi]; // see R19
			assign eff_out[gi]  = output_value_override_enable[gi] ? output_value_override_value[gi]
				: I_PORT_OUTPUT_BIT[gi]; // see R19
			assign eff_pull[gi] = (pullup_override_enable[gi] ? pullup_override_value[gi]
				: I_PORT_OUTPUT_BIT[gi]) & ~eff_dir[gi] & ~I_GLOBAL_PULLUP_DISABLE; // see R20
			assign eff_die[gi]  = input_enable_override_enable[gi] ? input_enable_override_value[gi]
				: DEFAULT_DIG_IN_EN[gi]; // see R19
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// State update
	pao_state_t st_q;
	pao_state_t st_d;

	// Next state: synchroniser chain and registered pad controls
	always_comb begin
		st_d           = st_q;
		st_d.sync1_q   = I_PAD_IN;
		st_d.sync2_q   = st_q.sync1_q;
		st_d.pad_out   = eff_out;
		st_d.pad_oe    = eff_dir;
		st_d.pullup_on = eff_pull;
		st_d.toggle    = toggle_override_enable;
		st_d.dig_in_en = eff_die;
		st_d.pin_in    = st_q.sync2_q & eff_die; // Disabled inputs read low
	end

	// Register with synchronous reset
	always_ff @(posedge I_SYS_CLK) begin
		if (!I_RST_N) begin
			st_q <= '{sync1_q: RST_SYNC, sync2_q: RST_SYNC, pad_out: RST_PAD_OUT, pad_oe: RST_PAD_OE,
				pullup_on: RST_PULLUP_ON, toggle: RST_TOGGLE, dig_in_en: RST_DIG_IN_EN, pin_in: RST_PIN_IN};
		end else begin
			st_q <= st_d;
		end
	end

	// Outputs straight from flip-flops
	assign O_PAD_OUT              = st_q.pad_out;
	assign O_PAD_OE               = st_q.pad_oe;
	assign O_PULLUP_ON            = st_q.pullup_on;
	assign O_PORT_TOGGLE          = st_q.toggle;
	assign O_DIGITAL_INPUT_ENABLE = st_q.dig_in_en;
	assign O_PIN_IN               = st_q.pin_in;

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge I_SYS_CLK); endclocking
	default disable iff (!I_RST_N);

	a_rx_forces_input: assert property ( // see R1 see R2
		rx_active |=> !O_PAD_OE[PIN_RXD])
		else $error("pin 0 drives while receiver enabled");

	a_rx_pullup: assert property ( // see R3
		(rx_active && I_PORT_OUTPUT_BIT[PIN_RXD] && !I_GLOBAL_PULLUP_DISABLE) |=> O_PULLUP_ON[PIN_RXD])
		else $error("pin 0 pull-up missing while forced input");

	a_lin_tx_drive: assert property ( // see R5
		I_LIN_TX_ENABLE |=> (O_PAD_OE[PIN_TXD] && O_PAD_OUT[PIN_TXD] == $past(I_LIN_TX_BIT)
			&& !O_PULLUP_ON[PIN_TXD]))
		else $error("pin 1 not driving LIN transmit bit");

	a_miso_priority: assert property ( // see R6 see R7
		spi_master |=> (!O_PAD_OE[PIN_MISO] && O_PAD_OUT[PIN_MISO] == $past(I_SPI_SLAVE_DATA_OUT)))
		else $error("pin 2 SPI master override wrong");

	a_miso_timer: assert property ( // see R7
		(!spi_master && !usi_do_alt && I_TIMER0_COMPARE_A_ENABLE)
			|=> O_PAD_OUT[PIN_MISO] == $past(I_TIMER0_COMPARE_A_OUT))
		else $error("pin 2 timer compare value lost");

	a_int1_input: assert property ( // see R8
		I_EXT_IRQ1_ENABLE |=> O_DIGITAL_INPUT_ENABLE[PIN_INT1])
		else $error("pin 3 input not forced on");

	a_analog_disable: assert property ( // see R9
		(I_ANALOG_PIN_DIGITAL_DISABLE[PIN_AREF] && !(pc_en && I_PIN_CHANGE_MASK_BIT[PIN_AREF]))
			|=> (!O_DIGITAL_INPUT_ENABLE[PIN_AREF] && !O_PIN_IN[PIN_AREF]))
		else $error("pin 7 input not disabled");

	a_pin7_plain: assert property ( // see R10 see R19
		1'b1 |=> (O_PAD_OE[PIN_AREF] == $past(I_DIRECTION_BIT[PIN_AREF])
			&& O_PAD_OUT[PIN_AREF] == $past(I_PORT_OUTPUT_BIT[PIN_AREF]) && !O_PORT_TOGGLE[PIN_AREF]))
		else $error("pin 7 overridden");

	a_sck_master: assert property ( // see R12 see R13
		spi_master |=> O_PAD_OUT[PIN_SCK] == $past(I_SPI_CLOCK_OUT))
		else $error("pin 5 SPI clock not driven");

	a_mosi_dir: assert property ( // see R16
		spi_master |=> !O_PAD_OE[PIN_MOSI])
		else $error("pin 4 direction not zero under SPI master");

	a_sck_toggle: assert property ( // see R17
		(I_TOGGLE_REQUEST && I_SERIAL_ALT_PIN_SELECT) |=> O_PORT_TOGGLE[PIN_SCK])
		else $error("pin 5 toggle override missing");

	a_start_input: assert property ( // see R18
		start_alt |=> (O_DIGITAL_INPUT_ENABLE[PIN_MOSI] && O_DIGITAL_INPUT_ENABLE[PIN_SCK]))
		else $error("pins 4 and 5 input not forced on");

	a_pullup_gate: assert property ( // see R20
		(|O_PULLUP_ON) |-> ((O_PULLUP_ON & O_PAD_OE) == 8'h00 && !$past(I_GLOBAL_PULLUP_DISABLE)))
		else $error("pull-up active on output or while disabled");

	a_sync_delay: assert property (
		(I_PIN_CHANGE_GROUP_ENABLE && I_PIN_CHANGE_MASK_BIT[PIN_TXD])[*4]
			|-> O_PIN_IN[PIN_TXD] == $past(I_PAD_IN[PIN_TXD], 3))
		else $error("pin 1 input latency wrong");

	c_lin_tx:     cover property (I_LIN_TX_ENABLE ##1 O_PAD_OE[PIN_TXD]);
	c_spi_master: cover property (spi_master ##1 O_PULLUP_ON[PIN_SCK] == 1'b0);
	c_two_wire:   cover property (two_wire_alt && I_DIRECTION_BIT[PIN_MOSI] ##1 !O_PAD_OUT[PIN_MOSI]);
	c_rx_pullup:  cover property (rx_active ##1 O_PULLUP_ON[PIN_RXD]);

endmodule : pao_port_a_override

//--- pao_pkg.sv
// Shared constants and state type for the port A override block
package pao_pkg;

	////////////////////////////////////////////////////////////////////////
	// Port geometry
	localparam int unsigned NUM_PINS = 8;

	// Pin positions
	localparam int unsigned PIN_RXD   = 0;
	localparam int unsigned PIN_TXD   = 1;
	localparam int unsigned PIN_MISO  = 2;
	localparam int unsigned PIN_INT1  = 3;
	localparam int unsigned PIN_MOSI  = 4;
	localparam int unsigned PIN_SCK   = 5;
	localparam int unsigned PIN_SS    = 6;
	localparam int unsigned PIN_AREF  = 7;

	////////////////////////////////////////////////////////////////////////
	// Values after reset
	localparam logic [7:0] RST_SYNC      = 8'h00;
	localparam logic [7:0] RST_PAD_OUT   = 8'h00;
	localparam logic [7:0] RST_PAD_OE    = 8'h00;
	localparam logic [7:0] RST_PULLUP_ON = 8'h00;
	localparam logic [7:0] RST_TOGGLE    = 8'h00;
	localparam logic [7:0] RST_DIG_IN_EN = 8'h00;
	localparam logic [7:0] RST_PIN_IN    = 8'h00;

	// Digital input enable when nothing overrides it
	localparam logic [7:0] DEFAULT_DIG_IN_EN = 8'hFF;

	////////////////////////////////////////////////////////////////////////
	// Complete registered state of the block
	typedef struct packed {
		logic [7:0] sync1_q;
		logic [7:0] sync2_q;
		logic [7:0] pad_out;
		logic [7:0] pad_oe;
		logic [7:0] pullup_on;
		logic [7:0] toggle;
		logic [7:0] dig_in_en;
		logic [7:0] pin_in;
	} pao_state_t;

endpackage : pao_pkg

//--- pao_pad_model.sv
// Pad model resolving the pin level seen by the port override block
`timescale 1ns/1ps

module pao_pad_model (
	// From the block
	input  wire logic [7:0] i_pad_out,
	input  wire logic [7:0] i_pad_oe,
	input  wire logic [7:0] i_pullup_on,
	// From the outside world
	input  wire logic [7:0] i_ext_level,
	input  wire logic [7:0] i_ext_drive,
	// To the block
	output logic      [7:0] o_pad_level
);
	////////////////////////////////////////////////////////////////////////
	// Own driver wins, then an outside driver, then the pull-up;
	// a floating pin shows the inverse of the current i_pad_out value
	assign o_pad_level = (i_pad_oe & i_pad_out)
		| (~i_pad_oe & i_ext_drive & i_ext_level)
		| (~i_pad_oe & ~i_ext_drive & (i_pullup_on | ~i_pad_out));
endmodule : pao_pad_model

//--- pao_testbench.sv
// Self-checking testbench for the port A override block
`timescale 1ns/1ps

module testbench;
	import pao_pkg::*;

	logic       clk, rst_n;
	logic [7:0] pb, db, pcm, adc, ext, pad, oout, ooe, opu, otg, odie, opin;
	logic       pu_dis, spi_en, ms, sck, mosi, miso, urx, lrx, ltx, ltb, tw, thw, alt;
	logic       sh, hold, tog, ssie, t0o, t0e, irq1, pcg;
	int         num_errors, cmp_count;

	////////////////////////////////////////////////////////////////////////
	// Clock generation
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// Design and pads
	pao_port_a_override DUT (
		.I_SYS_CLK(clk), .I_RST_N(rst_n), .I_PORT_OUTPUT_BIT(pb), .I_DIRECTION_BIT(db),
		.I_GLOBAL_PULLUP_DISABLE(pu_dis), .I_SPI_ENABLE_BIT(spi_en), .I_SPI_MASTER_SELECT(ms),
		.I_SPI_CLOCK_OUT(sck), .I_SPI_MASTER_DATA_OUT(mosi), .I_SPI_SLAVE_DATA_OUT(miso),
		.I_UART_RX_ENABLE(urx), .I_LIN_RX_ENABLE(lrx), .I_LIN_TX_ENABLE(ltx), .I_LIN_TX_BIT(ltb),
		.I_TWO_WIRE_MODE_ACTIVE(tw), .I_THREE_WIRE_MODE_ACTIVE(thw), .I_SERIAL_ALT_PIN_SELECT(alt),
		.I_SHIFTER_MSB_OUT(sh), .I_CLOCK_STRETCH_HOLD(hold), .I_TOGGLE_REQUEST(tog),
		.I_START_DETECT_IRQ_ENABLE(ssie), .I_TIMER0_COMPARE_A_OUT(t0o), .I_TIMER0_COMPARE_A_ENABLE(t0e),
		.I_EXT_IRQ1_ENABLE(irq1), .I_PIN_CHANGE_GROUP_ENABLE(pcg), .I_PIN_CHANGE_MASK_BIT(pcm),
		.I_ANALOG_PIN_DIGITAL_DISABLE(adc), .I_PAD_IN(pad), .O_PAD_OUT(oout), .O_PAD_OE(ooe),
		.O_PULLUP_ON(opu), .O_PORT_TOGGLE(otg), .O_DIGITAL_INPUT_ENABLE(odie), .O_PIN_IN(opin)
	);
	pao_pad_model PADS (
		.i_pad_out(oout), .i_pad_oe(ooe), .i_pullup_on(opu),
		.i_ext_level(ext), .i_ext_drive(8'hFF), .o_pad_level(pad)
	);

	////////////////////////////////////////////////////////////////////////
	// Comparison and run control
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic outs(input logic [7:0] e_oe, e_out, e_pu, e_tg, e_die);
		chk("pad_oe", e_oe, ooe);
		chk("pad_out", e_out, oout);
		chk("pullup_on", e_pu, opu);
		chk("port_toggle", e_tg, otg);
		chk("dig_in_en", e_die, odie);
	endtask : outs

	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_sim

	// Back to all-quiet inputs, then let outputs follow by one cycle
	task automatic idle;
		@(posedge clk);
		{pu_dis, spi_en, ms, sck, mosi, miso, urx, lrx, ltx, ltb, tw, thw, alt} <= '0;
		{sh, hold, tog, ssie, t0o, t0e, irq1, pcg} <= '0;
		{pb, db, pcm, adc, ext} <= '0;
		@(posedge clk);
	endtask : idle

	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : settle

	////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic s_plain;
		idle();
		pb <= 8'hA5; db <= 8'h0F; t0e <= 1'b1;
		settle(2);
		outs(8'h0F, 8'hA1, 8'hA0, 8'h00, 8'hFF);
		@(posedge clk);
		pu_dis <= 1'b1;
		settle(2);
		chk("pullup_on", 8'h00, opu);
	endtask : s_plain

	task automatic s_rx;
		for (int i = 0; i < 2; i++) begin
			idle();
			pb <= 8'h01; db <= 8'h01; urx <= (i == 0); lrx <= (i == 1);
			settle(2);
			outs(8'h00, 8'h01, 8'h01, 8'h00, 8'hFF);
		end
	endtask : s_rx

	task automatic s_ltx;
		idle();
		pb <= 8'h02; ltx <= 1'b1; ltb <= 1'b1;
		settle(2);
		outs(8'h02, 8'h02, 8'h00, 8'h00, 8'hFF);
		@(posedge clk);
		ltb <= 1'b0;
		settle(2);
		chk("pad_out", 8'h00, oout);
	endtask : s_ltx

	task automatic s_spi;
		idle();
		pb <= 8'h70; db <= 8'h80; spi_en <= 1'b1; ms <= 1'b1; sck <= 1'b1; miso <= 1'b1;
		tw <= 1'b1; thw <= 1'b1; alt <= 1'b1;
		settle(2);
		outs(8'h80, 8'h64, 8'h00, 8'h00, 8'hFF);
	endtask : s_spi

	task automatic s_twi;
		idle();
		db <= 8'h50; tw <= 1'b1; thw <= 1'b1; alt <= 1'b1; sh <= 1'b1; hold <= 1'b1;
		tog <= 1'b1; ssie <= 1'b1; adc <= 8'hF0; t0e <= 1'b1;
		settle(2);
		outs(8'h70, 8'h04, 8'h00, 8'h20, 8'h3F);
	endtask : s_twi

	task automatic s_din;
		idle();
		pcg <= 1'b1; pcm <= 8'h83; adc <= 8'hFF; irq1 <= 1'b1; ext <= 8'hFF;
		settle(4);
		chk("dig_in_en", 8'h8B, odie);
		chk("pin_in", 8'h8B, opin);
		@(posedge clk);
		pcg <= 1'b0;
		settle(2);
		chk("dig_in_en", 8'h08, odie);
	endtask : s_din

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		num_errors = 0;
		cmp_count = 0;
		rst_n = 1'b0;
		{pu_dis, spi_en, ms, sck, mosi, miso, urx, lrx, ltx, ltb, tw, thw, alt} = '0;
		{sh, hold, tog, ssie, t0o, t0e, irq1, pcg} = '0;
		{pcm, adc, ext} = '0;
		pb = 8'hFF;
		db = 8'hFF;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		#1;
		outs(8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
		s_plain();
		s_rx();
		s_ltx();
		s_spi();
		s_twi();
		s_din();
		end_sim();
	end
endmodule : testbench
